// ==== sild_driver.sv ====
// sild_driver: ten-stage shift register, level latch, blanking override
// assumes pin inputs are asynchronous to CLK_SYS; edges are found after sync
//
// Operation
// - ten shift stages, ten latches, ten outputs
// - first stage takes data on clock rise
// - later rises move stages toward serial out
// - last stage drives serial data output
// - latches follow stages while strobe high
// - blanking high forces every SRC_ON low and every SINK_ON high
// - blanking never disturbs latch contents
// - unblanked output follows its latch bit
`timescale 1ns/10ps
module sild_driver
   import sild_pkg::*;
(
   input  wire logic                  CLK_SYS,
   input  wire logic                  RESET_N,
   input  wire logic                  SER_DATA_IN,
   input  wire logic                  SHIFT_CLK,
   input  wire logic                  STROBE,
   input  wire logic                  BLANKING,
   output logic                       SER_DATA_OUT,
   output logic [SILD_WIDTH-1:0]      SRC_ON,
   output logic [SILD_WIDTH-1:0]      SINK_ON
);

////////////////////////////////////////////////////////////////////////
   // pin synchronisers, two flops each before any logic reads a pin
   logic data_s;
   logic clk_s;
   logic strobe_s;
   logic blank_s;
   logic clk_prev_q;
   logic clk_prev_d;
   logic clk_rise;

   sild_sync u_sync_data
   (
      .clk   (CLK_SYS),
      .rst_n (RESET_N),
      .pin   (SER_DATA_IN),
      .level (data_s)
   );

   sild_sync u_sync_clk
   (
      .clk   (CLK_SYS),
      .rst_n (RESET_N),
      .pin   (SHIFT_CLK),
      .level (clk_s)
   );

   sild_sync u_sync_strobe
   (
      .clk   (CLK_SYS),
      .rst_n (RESET_N),
      .pin   (STROBE),
      .level (strobe_s)
   );

   sild_sync u_sync_blank
   (
      .clk   (CLK_SYS),
      .rst_n (RESET_N),
      .pin   (BLANKING),
      .level (blank_s)
   );

   // rise of the synced shift clock; prev resets to the idle level
   always_comb
   begin
      clk_prev_d = clk_s;
      clk_rise   = clk_s & ~clk_prev_q;
   end

   always_ff @(posedge CLK_SYS)
   begin
      if (!RESET_N)
         clk_prev_q <= SILD_BIT_RST;
      else
         clk_prev_q <= clk_prev_d;
   end

////////////////////////////////////////////////////////////////////////
   // shift register and latch
   logic [SILD_WIDTH-1:0] shift_q;
   logic [SILD_WIDTH-1:0] shift_d;
   logic [SILD_WIDTH-1:0] latch_q;
   logic [SILD_WIDTH-1:0] latch_d;

   always_comb
   begin
      shift_d = shift_q;
      if (clk_rise)
         shift_d = {shift_q[SILD_WIDTH-2:0], data_s};
      latch_d = latch_q;
      if (strobe_s)
         latch_d = shift_q;
   end

   always_ff @(posedge CLK_SYS)
   begin
      if (!RESET_N)
      begin
         shift_q <= SILD_ZERO;
         latch_q <= SILD_ZERO;
      end
      else
      begin
         shift_q <= shift_d;
         latch_q <= latch_d;
      end
   end

////////////////////////////////////////////////////////////////////////
   // serial out and one registered drive cell per output
   logic                       sdo_q;
   logic                       sdo_d;
   wire logic [SILD_WIDTH-1:0] src_w;
   wire logic [SILD_WIDTH-1:0] sink_w;

   always_comb
   begin
      sdo_d = shift_q[SILD_WIDTH-1];
   end

   always_ff @(posedge CLK_SYS)
   begin
      if (!RESET_N)
         sdo_q <= SILD_BIT_RST;
      else
         sdo_q <= sdo_d;
   end

   for (genvar i = 0; i < SILD_WIDTH; i++)
   begin : g_drive
      sild_out_cell u_cell
      (
         .clk   (CLK_SYS),
         .rst_n (RESET_N),
         .held  (latch_q[i]),
         .blank (blank_s),
         .src   (src_w[i]),
         .sink  (sink_w[i])
      );
   end

   always_comb
   begin
      SER_DATA_OUT = sdo_q;
      SRC_ON       = src_w;
      SINK_ON      = sink_w;
   end

endmodule // sild_driver

////////////////////////////////////////////////////////////////////////
// sild_sync: two-flop synchroniser for one asynchronous pin
module sild_sync
   import sild_pkg::*;
#(
   parameter logic RST_VAL = SILD_BIT_RST
)
(
   input  wire logic clk,
   input  wire logic rst_n,
   input  wire logic pin,
   output logic      level
);

   logic meta_q;
   logic meta_d;
   logic sync_q;
   logic sync_d;

   always_comb
   begin
      meta_d = pin;
      sync_d = meta_q;
   end

   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         meta_q <= RST_VAL;
         sync_q <= RST_VAL;
      end
      else
      begin
         meta_q <= meta_d;
         sync_q <= sync_d;
      end
   end

   // only the second flop is seen outside
   always_comb
   begin
      level = sync_q;
   end

endmodule // sild_sync

////////////////////////////////////////////////////////////////////////
// sild_out_cell: source and sink enable of one output, from flops
module sild_out_cell
   import sild_pkg::*;
(
   input  wire logic clk,
   input  wire logic rst_n,
   input  wire logic held,
   input  wire logic blank,
   output logic      src,
   output logic      sink
);

   logic src_q;
   logic src_d;
   logic sink_q;
   logic sink_d;

   // source and sink never on together
   always_comb
   begin
      if (blank)
      begin
         src_d  = SILD_DRV_OFF;
         sink_d = SILD_DRV_ON;
      end
      else
      begin
         src_d  = held;
         sink_d = ~held;
      end
   end

   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         src_q  <= SILD_DRV_OFF;
         sink_q <= SILD_DRV_ON;
      end
      else
      begin
         src_q  <= src_d;
         sink_q <= sink_d;
      end
   end

   always_comb
   begin
      src  = src_q;
      sink = sink_q;
   end

endmodule // sild_out_cell

// ==== sild_pkg.sv ====
// sild_pkg: constants for the ten-output serial-in latched driver
// assumes a single 50 MHz system clock
package sild_pkg;
   localparam int          SILD_WIDTH      = 10;
   localparam int          SILD_CLK_NS     = 20;
   localparam int          SILD_STB_GAP_NS = 300;
   localparam int          SILD_STB_GAP_CY = (SILD_STB_GAP_NS + SILD_CLK_NS - 1) / SILD_CLK_NS;
   localparam logic [9:0]  SILD_ZERO       = 10'h000;
   localparam logic [9:0]  SILD_ONES       = 10'h3ff;
   localparam logic        SILD_BIT_RST    = 1'b0;
   localparam logic        SILD_DRV_OFF    = 1'b0;
   localparam logic        SILD_DRV_ON     = 1'b1;
endpackage : sild_pkg

// ==== sild_driver_asserts.sv ====
// sild_driver_asserts: port checks
// assumes CLK_SYS, sync RESET_N
`timescale 1ns/10ps
module sild_driver_asserts
   import sild_pkg::*;
(
   input wire logic                  CLK_SYS,
   input wire logic                  RESET_N,
   input wire logic                  SHIFT_CLK,
   input wire logic                  STROBE,
   input wire logic                  BLANKING,
   input wire logic                  SER_DATA_OUT,
   input wire logic [SILD_WIDTH-1:0] SRC_ON,
   input wire logic [SILD_WIDTH-1:0] SINK_ON
);
   default clocking @(posedge CLK_SYS);
   endclocking
   default disable iff (!RESET_N);
   a_sink_inv: assert property (SINK_ON == ~SRC_ON) else $error("sink");
   a_blank_off: assert property (BLANKING[*4] |-> SRC_ON == '0) else $error("blank");
   a_blank_sink: assert property (BLANKING[*4] |-> SINK_ON == SILD_ONES) else $error("blank sink");
   a_latch_hold: assert property ((!STROBE && !BLANKING)[*6] |=> $stable(SRC_ON)) else $error("hold");
   a_sdo_quiet: assert property ((!SHIFT_CLK)[*6] |=> $stable(SER_DATA_OUT)) else $error("sdo");
   a_latch_flow: assert property ((STROBE && !BLANKING && !SHIFT_CLK)[*8] |-> SRC_ON[9] == SER_DATA_OUT)
      else $error("flow");
endmodule // sild_driver_asserts
bind sild_driver sild_driver_asserts u_chk
(
   .CLK_SYS      (CLK_SYS),
   .RESET_N      (RESET_N),
   .SHIFT_CLK    (SHIFT_CLK),
   .STROBE       (STROBE),
   .BLANKING     (BLANKING),
   .SER_DATA_OUT (SER_DATA_OUT),
   .SRC_ON       (SRC_ON),
   .SINK_ON      (SINK_ON)
);

// ==== sild_host.sv ====
// sild_host: controller model on the serial pins
// assumes bench clock; drives on falling edges
`timescale 1ns/10ps
module sild_host
   import sild_pkg::*;
(
   input wire logic clk,
   output logic     sdi = 1'b0,
   output logic     sck = 1'b0,
   output logic     stb = 1'b0
);
   task automatic send(input logic [SILD_WIDTH-1:0] w);
      for (int i = SILD_WIDTH-1; i >= 0; i--)
      begin
         sdi = w[i];
         repeat (3) @(negedge clk);
         sck = 1'b1;
         repeat (3) @(negedge clk);
         sck = 1'b0;
      end
      sdi = ~sdi;
   endtask
   task automatic latch();
      repeat (SILD_STB_GAP_CY) @(negedge clk);
      stb = 1'b1;
      repeat (5) @(negedge clk);
      stb = 1'b0;
   endtask
   task automatic strobe_on();
      repeat (SILD_STB_GAP_CY) @(negedge clk);
      stb = 1'b1;
   endtask
   task automatic strobe_off();
      stb = 1'b0;
   endtask
endmodule // sild_host

// ==== sild_driver_bench.sv ====
// sild_driver_bench: directed tests
// assumes 50 MHz clock, reset held 20 cycles
`timescale 1ns/10ps
module sild_driver_bench
   import sild_pkg::*;
;
   logic clk = 1'b0, rst_n = 1'b0, blk = 1'b1, sdi, sck, stb, sdo;
   logic [SILD_WIDTH-1:0] src, sink;
   int num_errors = 0, cmp_count = 0;
   always #10 clk = ~clk;
   sild_host host (.clk(clk), .sdi(sdi), .sck(sck), .stb(stb));
   sild_driver DUT (.CLK_SYS(clk), .RESET_N(rst_n), .SER_DATA_IN(sdi), .SHIFT_CLK(sck), .STROBE(stb),
      .BLANKING(blk), .SER_DATA_OUT(sdo), .SRC_ON(src), .SINK_ON(sink));
   task automatic check(input logic [SILD_WIDTH-1:0] got, exp);
      cmp_count++;
      if (got !== exp)
      begin
         num_errors++;
         $display("Error at %0t: %h vs %h", $time, got, exp);
      end
   endtask
   task automatic report_and_stop();
      $display("compares %0d errors %0d", cmp_count, num_errors);
      if (num_errors == 0 && cmp_count > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   task automatic t_load();
      host.send(10'h2c5);
      host.latch();
      blk = 1'b0;
      repeat (6) @(negedge clk);
      check(src, 10'h2c5);
      check(sink, 10'h13a);
      $display("load done");
   endtask
   task automatic t_hold();
      host.send(10'h33a);
      repeat (6) @(negedge clk);
      check(src, 10'h2c5);
      check({9'h000, sdo}, 10'h001);
      $display("hold done");
   endtask
   task automatic t_blank();
      blk = 1'b1;
      repeat (6) @(negedge clk);
      check(src, SILD_ZERO);
      check(sink, SILD_ONES);
      blk = 1'b0;
      repeat (6) @(negedge clk);
      check(src, 10'h2c5);
      $display("blank done");
   endtask
   task automatic t_bypass();
      blk = 1'b1;
      host.strobe_on();
      host.send(10'h0b6);
      repeat (6) @(negedge clk);
      check(src, SILD_ZERO);
      check({9'h000, sdo}, 10'h000);
      blk = 1'b0;
      repeat (12) @(negedge clk);
      check(src, 10'h0b6);
      check(sink, 10'h349);
      host.strobe_off();
      host.send(10'h2aa);
      repeat (6) @(negedge clk);
      check(src, 10'h0b6);
      check({9'h000, sdo}, 10'h001);
      $display("bypass done");
   endtask
   task automatic t_reset();
      rst_n = 1'b0;
      repeat (2) @(negedge clk);
      rst_n = 1'b1;
      repeat (6) @(negedge clk);
      check(src, SILD_ZERO);
      check(sink, SILD_ONES);
      check({9'h000, sdo}, 10'h000);
      $display("reset done");
   endtask
   initial
   begin
      repeat (20) @(negedge clk);
      rst_n = 1'b1;
      @(negedge clk);
      t_load();
      t_hold();
      t_blank();
      t_bypass();
      t_reset();
      report_and_stop();
   end
   initial
   begin
      #100000;
      num_errors++;
      report_and_stop();
   end
endmodule // sild_driver_bench
